// [ivc_pkg.sv]
// package of constants for the interrupt vector and external interrupt controller
// assumes a single cpu clock and a synchronous active-low reset
//
// Functional notes
// - reset vector FFFE highest, trap FFFC below, auto wake-up source 0 at FFFA
// - auto wake-up source leaves auto-wakeup halt mode only, never ordinary halt
// - second time base is source 5 at FFF0, no halt wake; source 6 unused
// - reload timer compare/capture is source 8 at FFEA, no active-halt wake
// - reload timer overflow is source 9 at FFE8, wakes active-halt, not halt
// - light timer capture is source 10 at FFE6, no active-halt wake
// - first time base is source 11 at FFE4, wakes active-halt
// - sense register: line3 bits 7:6, line2 5:4, line1 3:2, line0 1:0
// - sense code 00 falling plus low, 01 rising, 10 falling, 11 both edges
// - sense register writes accepted only while cpu interrupt mask is set
// - sense register resets to 00h
// - pin select resets to 0Ch: PA7 line1, PA0 line0, PB3 line2, PB0 line3
// - pin select 7:6 picks PB0, PB1 or PB2 for line 3
// - edge requests latched, cleared when cpu enters matching service routine
// - enabled pins sharing one line are combined before edge/level detection
// - fixed priority picks which pending source is serviced first
// - pin select 5:4 PB3..6 line2, 3:2 PA4..7 line1, 1:0 PA0..3 line0
package ivc_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0]  ADDR_SENSE      = 8'h00;
  localparam logic [7:0]  ADDR_PINSEL     = 8'h01;
  localparam logic [7:0]  SENSE_RESET     = 8'h00;
  localparam logic [7:0]  PINSEL_RESET    = 8'h0C;
  localparam int          FIELD_W         = 2;
  // --------------------------------------------------------------
  // sensitivity codes
  // --------------------------------------------------------------
  localparam logic [1:0]  SENSE_FALL_LOW  = 2'h0;
  localparam logic [1:0]  SENSE_RISE      = 2'h1;
  localparam logic [1:0]  SENSE_FALL      = 2'h2;
  localparam logic [1:0]  SENSE_BOTH      = 2'h3;
  // --------------------------------------------------------------
  // vectors and sources
  // --------------------------------------------------------------
  localparam logic [15:0] VEC_RESET       = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP        = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0        = 16'hFFFA;
  localparam int          NUM_SRC         = 14;
  localparam int          NUM_LINES       = 4;
  localparam int          EXT_SRC_BASE    = 1;
  localparam logic [3:0]  SRC_NONE        = 4'hF;
  // sources that exist: 6 and 13 are unused
  localparam logic [13:0] SRC_USED        = 14'h1FBF;
  // sources that leave halt: lines 0..3 (sources 1..4) and serial interface 12
  localparam logic [13:0] WAKE_HALT_MASK  = 14'h101E;
  // auto-wakeup halt adds source 0
  localparam logic [13:0] WAKE_AWU_MASK   = 14'h101F;
  // active-halt: reload overflow 9 and first time base 11
  localparam logic [13:0] WAKE_ACT_MASK   = 14'h0A00;
endpackage : ivc_pkg

// [ivc_ctrl.sv]
// interrupt mapping, priority and external interrupt front end
// assumes peripheral requests are already enabled levels and all inputs are synchronous to clock
`timescale 1ns/10ps
module ivc_ctrl (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // cpu side
  input  wire logic        cc_i_mask,
  input  wire logic        trap_req,
  input  wire logic        irq_ack,
  input  wire logic [3:0]  ack_source,
  output logic             irq_req,
  output logic      [3:0]  irq_source,
  output logic      [15:0] irq_vector,
  // peripheral requests, one per source; bits 1..4 ignored
  input  wire logic [13:0] periph_req,
  // port pins and their interrupt enables
  input  wire logic [7:0]  port_a,
  input  wire logic [6:0]  port_b,
  input  wire logic [7:0]  port_a_int_en,
  input  wire logic [6:0]  port_b_int_en,
  // wake-up indications
  output logic             wake_halt,
  output logic             wake_awu_halt,
  output logic             wake_active_halt
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  sense;
    logic [7:0]  pinsel;
    logic [3:0]  line_prev;
    logic [3:0]  line_latch;
    logic [7:0]  rdata;
    logic        req;
    logic [3:0]  src;
    logic [15:0] vec;
    logic        wk_halt;
    logic        wk_awu;
    logic        wk_act;
  } ivc_state_t;

  ivc_state_t state_q;
  ivc_state_t state_d;

  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------
  // and of enabled pins in a group; the selected pin always takes part
  function automatic logic line_combine(input logic [3:0] pins, input logic [3:0] en,
                                        input logic [1:0] sel);
    logic v;
    v = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (en[i] || (sel == 2'(i))) begin
        v = v & pins[i];
      end
    end
    return v;
  endfunction

  // lowest numbered pending source wins
  function automatic logic [3:0] pick_source(input logic [13:0] pend);
    logic [3:0] s;
    s = ivc_pkg::SRC_NONE;
    for (int i = ivc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        s = 4'(i);
      end
    end
    return s;
  endfunction

  // --------------------------------------------------------------
  // pin selection and combining
  // --------------------------------------------------------------
  logic [3:0] line_lvl;
  logic [3:0] line_fall;
  logic [3:0] line_rise;
  logic [3:0] line_edge;
  logic [3:0] line_req;
  logic [13:0] pending;
  logic [3:0] top_src;

  always_comb begin
    line_lvl[0] = line_combine(port_a[3:0], port_a_int_en[3:0], state_q.pinsel[1:0]);
    line_lvl[1] = line_combine(port_a[7:4], port_a_int_en[7:4], state_q.pinsel[3:2]);
    line_lvl[2] = line_combine(port_b[6:3], port_b_int_en[6:3], state_q.pinsel[5:4]);
    line_lvl[3] = line_combine({1'b1, port_b[2:0]}, {1'b0, port_b_int_en[2:0]},
                               state_q.pinsel[7:6]);
  end

  // --------------------------------------------------------------
  // edge and level detection
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ivc_pkg::NUM_LINES; g++) begin : g_line
      logic [1:0] mode;
      assign mode         = state_q.sense[g*ivc_pkg::FIELD_W +: ivc_pkg::FIELD_W];
      assign line_fall[g] = state_q.line_prev[g] & ~line_lvl[g];
      assign line_rise[g] = ~state_q.line_prev[g] & line_lvl[g];
      always_comb begin
        case (mode)
          ivc_pkg::SENSE_FALL_LOW: line_edge[g] = line_fall[g];
          ivc_pkg::SENSE_RISE:     line_edge[g] = line_rise[g];
          ivc_pkg::SENSE_FALL:     line_edge[g] = line_fall[g];
          ivc_pkg::SENSE_BOTH:     line_edge[g] = line_fall[g] | line_rise[g];
          default:                 line_edge[g] = 1'b0;
        endcase
      end
      // low level requests directly in mode 00
      assign line_req[g] = state_q.line_latch[g] |
                           ((mode == ivc_pkg::SENSE_FALL_LOW) & ~line_lvl[g]);
    end
  endgenerate

  // --------------------------------------------------------------
  // request map and priority
  // --------------------------------------------------------------
  always_comb begin
    pending = periph_req;
    pending[ivc_pkg::EXT_SRC_BASE +: ivc_pkg::NUM_LINES] = line_req;
    pending = pending & ivc_pkg::SRC_USED;
  end

  assign top_src = pick_source(pending);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.line_prev = line_lvl;
    // set wins over clear on acknowledge
    for (int i = 0; i < ivc_pkg::NUM_LINES; i++) begin
      if (irq_ack && (ack_source == 4'(i + ivc_pkg::EXT_SRC_BASE))) begin
        state_d.line_latch[i] = 1'b0;
      end
      if (line_edge[i]) begin
        state_d.line_latch[i] = 1'b1;
      end
    end
    if (reg_wr && (reg_addr == ivc_pkg::ADDR_SENSE) && cc_i_mask) begin
      state_d.sense = reg_wdata;
    end
    if (reg_wr && (reg_addr == ivc_pkg::ADDR_PINSEL)) begin
      state_d.pinsel = reg_wdata;
    end
    state_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ivc_pkg::ADDR_SENSE:  state_d.rdata = state_q.sense;
        ivc_pkg::ADDR_PINSEL: state_d.rdata = state_q.pinsel;
        default:              state_d.rdata = 8'h00;
      endcase
    end
    // trap ignores the mask and outranks every source
    if (trap_req) begin
      state_d.req = 1'b1;
      state_d.src = ivc_pkg::SRC_NONE;
      state_d.vec = ivc_pkg::VEC_TRAP;
    end else if (top_src != ivc_pkg::SRC_NONE) begin
      state_d.req = ~cc_i_mask;
      state_d.src = top_src;
      state_d.vec = 16'(ivc_pkg::VEC_SRC0 - {11'h000, top_src, 1'b0});
    end else begin
      state_d.req = 1'b0;
      state_d.src = ivc_pkg::SRC_NONE;
      state_d.vec = ivc_pkg::VEC_RESET;
    end
    state_d.wk_halt = |(pending & ivc_pkg::WAKE_HALT_MASK);
    state_d.wk_awu  = |(pending & ivc_pkg::WAKE_AWU_MASK);
    state_d.wk_act  = |(pending & ivc_pkg::WAKE_ACT_MASK);
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q            <= '0;
      state_q.sense      <= ivc_pkg::SENSE_RESET;
      state_q.pinsel     <= ivc_pkg::PINSEL_RESET;
      state_q.line_prev  <= 4'hF;
      state_q.src        <= ivc_pkg::SRC_NONE;
      state_q.vec        <= ivc_pkg::VEC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign reg_rdata        = state_q.rdata;
  assign irq_req          = state_q.req;
  assign irq_source       = state_q.src;
  assign irq_vector       = state_q.vec;
  assign wake_halt        = state_q.wk_halt;
  assign wake_awu_halt    = state_q.wk_awu;
  assign wake_active_halt = state_q.wk_act;

endmodule // ivc_ctrl

// [ivc_ctrl_monitor.sv]
// checker for ivc_ctrl outputs: vector map, priority and wake rules
// assumes it is bound onto ivc_ctrl, one clock, synchronous active-low reset
`timescale 1ns/10ps
module ivc_ctrl_mon (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // register port and cpu side
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic        cc_i_mask,
  input wire logic        trap_req,
  input wire logic        irq_req,
  input wire logic [3:0]  irq_source,
  input wire logic [15:0] irq_vector,
  // peripheral requests
  input wire logic [13:0] periph_req,
  // wake indications
  input wire logic        wake_halt,
  input wire logic        wake_awu_halt,
  input wire logic        wake_active_halt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_trap_vector: assert property (trap_req |=> irq_req && irq_vector == 16'hFFFC)
    else $error("trap vector wrong");
  a_src_vector: assert property (irq_source != 4'hF |-> irq_vector == 16'hFFFA - {11'h000, irq_source, 1'b0})
    else $error("source vector wrong");
  a_unused_src: assert property (irq_source != 4'h6 && irq_source != 4'hD)
    else $error("unused source shown");
  a_awu_first: assert property (periph_req[0] && !trap_req |=> irq_source == 4'h0)
    else $error("source 0 lost priority");
  a_halt_in_awu: assert property (wake_halt |-> wake_awu_halt)
    else $error("halt wake without awu wake");
  a_act_cause: assert property (wake_active_halt |-> |($past(periph_req) & 14'h0A00))
    else $error("active-halt wake without cause");
  a_prio_order: assert property (irq_source > 4'h5 && irq_source != 4'hF |-> ($past(periph_req) & 14'h0021) == 14'h0)
    else $error("lower priority source won");
  a_awu_wake: assert property (periph_req[0] && (periph_req & 14'h0A00) == 14'h0 |=> wake_awu_halt && !wake_active_halt)
    else $error("awu wake wrong");
  c_trap: cover property (trap_req);
  c_line1: cover property (irq_req && irq_source == 4'h2);
  c_sense_wr: cover property (reg_wr && reg_addr == 8'h00 && cc_i_mask);
endmodule // ivc_ctrl_mon

bind ivc_ctrl ivc_ctrl_mon u_mon (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .cc_i_mask(cc_i_mask),
  .trap_req(trap_req), .irq_req(irq_req), .wake_halt(wake_halt), .wake_awu_halt(wake_awu_halt),
  .wake_active_halt(wake_active_halt), .reg_addr(reg_addr), .irq_source(irq_source),
  .irq_vector(irq_vector), .periph_req(periph_req));

// [ivc_cpu_model.sv]
// cpu model: enters the service routine of a pending request after a fixed wait
// assumes irq_req and irq_source come from ivc_ctrl on the same clock
`timescale 1ns/10ps
module ivc_cpu_model #(parameter int DELAY = 4) (
  input  wire logic       clock,
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_source,
  output logic            irq_ack,
  output logic      [3:0] ack_source
);
  int wait_q = 0;
  initial begin
    irq_ack    = 1'b0;
    ack_source = 4'h5;
  end
  always @(posedge clock) begin
    irq_ack    <= 1'b0;
    ack_source <= ~ack_source;
    wait_q     <= irq_req ? wait_q + 1 : 0;
    if (irq_req && wait_q == DELAY) begin
      irq_ack    <= 1'b1;
      ack_source <= irq_source;
      wait_q     <= 0;
    end
  end
endmodule // ivc_cpu_model

// [irq_vector_and_ext_interrupt_ctrl_test.sv]
// self-checking bench for ivc_ctrl with a cpu model on the far side
// assumes ivc_pkg, ivc_ctrl, ivc_cpu_model and the checker are compiled first
`timescale 1ns/10ps
module irq_vector_and_ext_interrupt_ctrl_test;
  logic        clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cc_i_mask = 1'b1, trap_req = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        irq_ack, irq_req, wake_halt, wake_awu_halt, wake_active_halt;
  logic [3:0]  ack_source, irq_source;
  logic [15:0] irq_vector;
  logic [13:0] periph_req = 14'h0000;
  logic [14:0] pins = 15'h7FFF, pin_en = 15'h7FFF;
  int          fails = 0, cmp_count = 0, cycles = 0;
  logic [13:0] req_tab [9] = '{14'h0001, 14'h0020, 14'h0040, 14'h0100, 14'h0200, 14'h0400, 14'h0800, 14'h1000, 14'h1221};
  logic [3:0]  src_tab [9] = '{4'h0, 4'h5, 4'hF, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'h0};
  logic [2:0]  wake_tab [9] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h6, 3'h7};
  ivc_ctrl dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cc_i_mask(cc_i_mask), .trap_req(trap_req), .irq_ack(irq_ack),
    .ack_source(ack_source), .irq_req(irq_req), .irq_source(irq_source), .irq_vector(irq_vector),
    .periph_req(periph_req), .port_a(pins[7:0]), .port_b(pins[14:8]), .port_a_int_en(pin_en[7:0]),
    .port_b_int_en(pin_en[14:8]), .wake_halt(wake_halt), .wake_awu_halt(wake_awu_halt),
    .wake_active_halt(wake_active_halt));
  ivc_cpu_model cpu (.clock(clock), .irq_req(irq_req), .irq_source(irq_source), .irq_ack(irq_ack),
    .ack_source(ack_source));
  initial forever #5 clock = ~clock;
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic sees(input int n, input logic [3:0] src, input logic req);
    repeat (n) @(posedge clock);
    #1 chk("irq_source", {12'h000, src}, {12'h000, irq_source});
    chk("irq_vector", src == 4'hF ? 16'hFFFE : 16'hFFFA - {11'h000, src, 1'b0}, irq_vector);
    chk("irq_req", {15'h0000, req}, {15'h0000, irq_req});
  endtask
  task automatic ext_run(input logic [7:0] psel, input logic [1:0] mode);
    int pos [4];
    pos = '{int'(psel[1:0]), 4 + int'(psel[3:2]), 11 + int'(psel[5:4]), 8 + int'(psel[7:6])};
    cc_i_mask <= 1'b1;
    wr(8'h00, {4{mode}});
    wr(8'h01, psel);
    @(posedge clock) cc_i_mask <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(posedge clock) pins[pos[n]] <= 1'b0;
      sees(3, mode == 2'h1 ? 4'hF : 4'(n + 1), mode != 2'h1);
      chk("wake_halt", {15'h0000, mode != 2'h1}, {15'h0000, wake_halt});
      @(posedge clock) pins[pos[n]] <= 1'b1;
      if (mode == 2'h1) sees(3, 4'(n + 1), 1'b1);
      sees(14, 4'hF, 1'b0);
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h0C);
    rd(8'h05, 8'h00);
    cc_i_mask <= 1'b0;
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    $display("register test done");
    for (int m = 0; m < 4; m++) ext_run(8'h0C, 2'(m));
    ext_run(8'h55, 2'h2);
    ext_run(8'hAA, 2'h3);
    @(posedge clock) pins[0] <= 1'b0;
    sees(3, 4'h1, 1'b1);
    @(posedge clock) pins[0] <= 1'b1;
    sees(14, 4'hF, 1'b0);
    @(posedge clock) pin_en[0] <= 1'b0;
    pins[0] <= 1'b0;
    sees(3, 4'hF, 1'b0);
    @(posedge clock) pins[0] <= 1'b1;
    pin_en[0] <= 1'b1;
    rd(8'h01, 8'hAA);
    rd(8'h00, 8'hFF);
    $display("external line test done");
    for (int i = 0; i < 9; i++) begin
      @(posedge clock) periph_req <= req_tab[i];
      sees(2, src_tab[i], src_tab[i] != 4'hF);
      chk("wake", {13'h0000, wake_tab[i]}, {13'h0000, wake_halt, wake_awu_halt, wake_active_halt});
    end
    @(posedge clock) cc_i_mask <= 1'b1;
    sees(2, 4'h0, 1'b0);
    $display("priority test done");
    @(posedge clock) trap_req <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("trap_vector", 16'hFFFC, irq_vector);
    chk("trap_req", 16'h0001, {15'h0000, irq_req});
    @(posedge clock) trap_req <= 1'b0;
    periph_req <= 14'h0000;
    $display("trap test done");
    tally_and_finish();
  end
endmodule // irq_vector_and_ext_interrupt_ctrl_test
